/* common/mlo_params.svh */
// Constants for the margin, threshold and options register group
// Operation
// - Margin-low mode lowers reference by step offset
// - Loop slave: for margin-low and select only, ignore writes, refuse, fault, alert
// - Margin-low is linear, exponent minus nine
// - Valid margin-low range is -64 to -1
// - Out-of-range value clamps, alerts, sets invalid data flag
// - Reference bounded by max and min limits
// - Reference ramps at state-dependent rate
// - Margin-low bit access and sign extension
// - Margin-low restores fff7h or fff1h by select
// - Threshold select: two bits, upper bits zero
// - Select picks UV/OV warn percentages
// - Power-good drops beyond warn thresholds
// - Power-good recovers below 105 or above 95
// - Options register fifteen writable bits, 7fe7h-masked image stored on store-all
// - Negative-limit disable bit turns protection off
// - Pin select: both settings drive the same power-good output
// - Converter-enable clear holds readings
// - Voltage-only bit stops current and temperature
// - Margin-high restores 0009h or 000fh by select
`ifndef MLO_PARAMS_SVH
`define MLO_PARAMS_SVH
`define MLO_CMD_MARGIN_LOW   8'hD6
`define MLO_CMD_PCT_SEL      8'hD7
`define MLO_CMD_OPTIONS      8'hE5
`define MLO_ML_MIN           16'hFFC0
`define MLO_ML_MAX           16'hFFFF
`define MLO_ML_RESTORE0      16'hFFF7
`define MLO_ML_RESTORE1      16'hFFF1
`define MLO_MH_RESTORE0      16'h0009
`define MLO_MH_RESTORE1      16'h000F
`define MLO_OPT_RESET        16'h1184
`define MLO_OPT_NV_MASK      16'h7FE7
`define MLO_ML_WMASK         16'h803F
`define MLO_PCT_WMASK        8'h03
`define MLO_OPT_NEGLIM_BIT   0
`define MLO_OPT_PINSEL_BIT   1
`define MLO_OPT_RUN_BIT      2
`define MLO_OPT_VONLY_BIT    3
`define MLO_OPT_RSMLO_BIT    13
`define MLO_OPT_RSMHI_BIT    14
`define MLO_PG_HYST_HI       8'd105
`define MLO_PG_HYST_LO       8'd95
`endif

/* common/mlo_pkg.sv */
// Types for the margin, threshold and options register group
package mlo_pkg;
  typedef enum logic [1:0] {
    MLO_RAMP_SOFT_START = 2'b00,
    MLO_RAMP_STEADY     = 2'b01,
    MLO_RAMP_OFF_DELAY  = 2'b10,
    MLO_RAMP_SOFT_STOP  = 2'b11
  } mlo_ramp_state_t;
  typedef enum logic [1:0] {
    MLO_PG_GOOD = 2'b00,
    MLO_PG_OVER = 2'b01,
    MLO_PG_UNDR = 2'b10
  } mlo_pg_state_t;
endpackage : mlo_pkg

/* hw/mlo_regs.sv */
// Margin-low, threshold select and options registers with reference and power-good logic
`timescale 1ns/100ps
`include "mlo_params.svh"
module mlo_regs #(
  parameter int REF_W = 12
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      cmd_valid_i,
  input  wire logic                      cmd_write_i,
  input  wire logic [7:0]                cmd_code_i,
  input  wire logic [15:0]               cmd_wdata_i,
  input  wire logic                      loop_slave_i,
  input  wire logic                      restore_i,
  input  wire logic                      store_all_i,
  input  wire logic                      margin_low_sel_i,
  input  wire logic                      margin_high_sel_i,
  input  wire logic [REF_W-1:0]          base_ref_i,
  input  wire logic [REF_W-1:0]          ref_max_i,
  input  wire logic [REF_W-1:0]          ref_min_i,
  input  wire logic [15:0]               trim_i,
  input  wire mlo_pkg::mlo_ramp_state_t  ramp_state_i,
  input  wire logic [7:0]                rate_rise_i,
  input  wire logic [7:0]                rate_trans_i,
  input  wire logic [7:0]                rate_fall_i,
  input  wire logic [7:0]                fb_pct_i,
  input  wire logic                      sample_i,
  input  wire logic [15:0]               vout_sample_i,
  input  wire logic [15:0]               iout_sample_i,
  input  wire logic [15:0]               temp_sample_i,
  output logic [15:0]                    cmd_rdata_o,
  output logic                           cmd_ack_o,
  output logic                           cmd_nack_o,
  output logic                           invalid_command_fault_o,
  output logic                           invalid_data_o,
  output logic                           alert_o,
  output logic [15:0]                    nv_options_o,
  output logic                           nv_store_o,
  output logic [REF_W-1:0]               amp_reference_o,
  output logic                           reset_or_good_pin_o,
  output logic                           neg_limit_enable_o,
  output logic                           meas_iout_temp_o,
  output logic [15:0]                    read_vout_o,
  output logic [15:0]                    read_iout_o,
  output logic [15:0]                    read_temp_o,
  output logic [15:0]                    margin_high_step_o
);
  logic [15:0]            margin_low_step;
  logic [1:0]             pct_threshold_select;
  logic [15:0]            option_bits;
  logic                   hit_guarded;
  logic                   hit_opt;
  logic                   refuse;
  logic [15:0]            ml_in;
  logic                   ml_bad;
  logic [15:0]            ml_clamped;
  logic signed [REF_W+1:0] next_target;
  logic [REF_W-1:0]       target;
  logic [7:0]             rate;
  logic [7:0]             uv_warn;
  logic [7:0]             ov_warn;
  mlo_pkg::mlo_pg_state_t pg_state;
  mlo_pkg::mlo_pg_state_t next_pg;

  assign hit_guarded = cmd_code_i == `MLO_CMD_MARGIN_LOW || cmd_code_i == `MLO_CMD_PCT_SEL;
  assign hit_opt     = cmd_code_i == `MLO_CMD_OPTIONS;
  assign refuse      = cmd_valid_i && loop_slave_i && hit_guarded;
  // Writable low bits sit in a sign-extended word
  assign ml_in       = {8'hFF, cmd_wdata_i[7:0]};
  assign ml_bad      = cmd_wdata_i[15:8] != 8'hFF || cmd_wdata_i[7:6] != 2'b11;
  assign ml_clamped  = cmd_wdata_i[15] ? `MLO_ML_MIN : `MLO_ML_MAX;

  // Margin-low step register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      margin_low_step <= `MLO_ML_RESTORE0;
    end else if (restore_i) begin
      margin_low_step <= option_bits[`MLO_OPT_RSMLO_BIT] ? `MLO_ML_RESTORE1
                                                         : `MLO_ML_RESTORE0;
    end else if (cmd_valid_i && cmd_write_i && !refuse
                 && cmd_code_i == `MLO_CMD_MARGIN_LOW) begin
      margin_low_step <= ml_bad ? ml_clamped : ml_in;
    end
  end

  // Margin-high restore value follows its select
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      margin_high_step_o <= `MLO_MH_RESTORE0;
    end else if (restore_i) begin
      margin_high_step_o <= option_bits[`MLO_OPT_RSMHI_BIT] ? `MLO_MH_RESTORE1
                                                            : `MLO_MH_RESTORE0;
    end
  end

  // Threshold select register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pct_threshold_select <= 2'b00;
    end else if (cmd_valid_i && cmd_write_i && !refuse && cmd_code_i == `MLO_CMD_PCT_SEL) begin
      pct_threshold_select <= 2'(cmd_wdata_i[7:0] & `MLO_PCT_WMASK);
    end
  end

  // Options register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      option_bits <= `MLO_OPT_RESET;
    end else if (cmd_valid_i && cmd_write_i && hit_opt) begin
      option_bits <= {1'b0, cmd_wdata_i[14:0]};
    end
  end

  // Nonvolatile image of the options word on store-all
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nv_options_o <= 16'h0000;
      nv_store_o   <= 1'b0;
    end else begin
      nv_store_o <= store_all_i;
      if (store_all_i) begin
        nv_options_o <= option_bits & `MLO_OPT_NV_MASK;
      end
    end
  end

  // Command answer, read data and fault flags
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_ack_o               <= 1'b0;
      cmd_nack_o              <= 1'b0;
      cmd_rdata_o             <= 16'h0000;
      invalid_command_fault_o <= 1'b0;
      invalid_data_o          <= 1'b0;
      alert_o                 <= 1'b0;
    end else begin
      cmd_ack_o  <= cmd_valid_i && !refuse && (hit_guarded || hit_opt);
      cmd_nack_o <= cmd_valid_i && (refuse || !(hit_guarded || hit_opt));
      if (cmd_valid_i && !cmd_write_i && !refuse) begin
        if (cmd_code_i == `MLO_CMD_MARGIN_LOW) begin
          cmd_rdata_o <= margin_low_step;
        end else if (cmd_code_i == `MLO_CMD_PCT_SEL) begin
          cmd_rdata_o <= {14'h0, pct_threshold_select};
        end else if (hit_opt) begin
          cmd_rdata_o <= option_bits;
        end else begin
          cmd_rdata_o <= 16'h0000;
        end
      end
      if (refuse) begin
        invalid_command_fault_o <= 1'b1;
        alert_o                 <= 1'b1;
      end
      if (cmd_valid_i && cmd_write_i && !refuse && cmd_code_i == `MLO_CMD_MARGIN_LOW
          && ml_bad) begin
        invalid_data_o <= 1'b1;
        alert_o        <= 1'b1;
      end
    end
  end

  // Target reference: base plus trim and margins, in 1.953 mV steps
  always_comb begin
    next_target = $signed({2'b00, base_ref_i}) + $signed(trim_i[REF_W+1:0]);
    if (margin_high_sel_i) begin
      next_target = next_target + $signed(margin_high_step_o[REF_W+1:0]);
    end
    if (margin_low_sel_i) begin
      next_target = next_target + $signed(margin_low_step[REF_W+1:0]);
    end
    if (next_target > $signed({2'b00, ref_max_i})) begin
      target = ref_max_i;
    end else if (next_target < $signed({2'b00, ref_min_i})) begin
      target = ref_min_i;
    end else begin
      target = next_target[REF_W-1:0];
    end
  end

  // Ramp rate by converter state
  always_comb begin
    case (ramp_state_i)
      mlo_pkg::MLO_RAMP_SOFT_START: rate = rate_rise_i;
      mlo_pkg::MLO_RAMP_SOFT_STOP:  rate = rate_fall_i;
      default:                      rate = rate_trans_i;
    endcase
  end

  // Reference moves up to rate steps per clock cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      amp_reference_o <= '0;
    end else if (amp_reference_o < target) begin
      amp_reference_o <= (target - amp_reference_o > REF_W'(rate)) ?
                         amp_reference_o + REF_W'(rate) : target;
    end else if (amp_reference_o > target) begin
      amp_reference_o <= (amp_reference_o - target > REF_W'(rate)) ?
                         amp_reference_o - REF_W'(rate) : target;
    end
  end

  // Warn thresholds per select
  always_comb begin
    case (pct_threshold_select)
      2'b00:   begin uv_warn = 8'd88; ov_warn = 8'd112; end
      2'b01:   begin uv_warn = 8'd90; ov_warn = 8'd110; end
      2'b10:   begin uv_warn = 8'd78; ov_warn = 8'd112; end
      default: begin uv_warn = 8'd64; ov_warn = 8'd112; end
    endcase
  end

  // Power-good state with hysteresis
  always_comb begin
    next_pg = pg_state;
    case (pg_state)
      mlo_pkg::MLO_PG_GOOD: begin
        if (fb_pct_i > ov_warn) next_pg = mlo_pkg::MLO_PG_OVER;
        else if (fb_pct_i < uv_warn) next_pg = mlo_pkg::MLO_PG_UNDR;
      end
      mlo_pkg::MLO_PG_OVER: begin
        if (fb_pct_i < `MLO_PG_HYST_HI) next_pg = mlo_pkg::MLO_PG_GOOD;
      end
      mlo_pkg::MLO_PG_UNDR: begin
        if (fb_pct_i > `MLO_PG_HYST_LO) next_pg = mlo_pkg::MLO_PG_GOOD;
      end
      default: next_pg = mlo_pkg::MLO_PG_GOOD;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pg_state            <= mlo_pkg::MLO_PG_UNDR;
      reset_or_good_pin_o <= 1'b0;
    end else begin
      pg_state            <= next_pg;
      // Low when not good; both pin select settings give the same sense
      reset_or_good_pin_o <= option_bits[`MLO_OPT_PINSEL_BIT] ? (next_pg == mlo_pkg::MLO_PG_GOOD)
                                                              : (next_pg == mlo_pkg::MLO_PG_GOOD);
    end
  end

  // Protection and measurement controls
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      neg_limit_enable_o <= 1'b1;
      meas_iout_temp_o   <= 1'b1;
      read_vout_o        <= 16'h0000;
      read_iout_o        <= 16'h0000;
      read_temp_o        <= 16'h0000;
    end else begin
      neg_limit_enable_o <= !option_bits[`MLO_OPT_NEGLIM_BIT];
      meas_iout_temp_o   <= option_bits[`MLO_OPT_RUN_BIT] && !option_bits[`MLO_OPT_VONLY_BIT];
      if (sample_i && option_bits[`MLO_OPT_RUN_BIT]) begin
        read_vout_o <= vout_sample_i;
        if (!option_bits[`MLO_OPT_VONLY_BIT]) begin
          read_iout_o <= iout_sample_i;
          read_temp_o <= temp_sample_i;
        end
      end
    end
  end

  AST_SLAVE_NACK: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    refuse |=> cmd_nack_o && alert_o && invalid_command_fault_o)
    else $error("Loop slave access not refused");
  AST_SLAVE_NOWRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    refuse && !restore_i |=> $stable(margin_low_step) && $stable(pct_threshold_select))
    else $error("Loop slave write changed a register");
  AST_ML_RANGE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    margin_low_step[15:6] == 10'h3FF)
    else $error("Margin-low outside -64..-1");
  AST_ML_CLAMP: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    cmd_valid_i && cmd_write_i && !refuse && !restore_i && cmd_code_i == `MLO_CMD_MARGIN_LOW
    && ml_bad |=> invalid_data_o && alert_o)
    else $error("Bad margin-low not flagged");
  AST_ML_RESTORE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    restore_i |=> margin_low_step == ($past(option_bits[`MLO_OPT_RSMLO_BIT]) ?
    `MLO_ML_RESTORE1 : `MLO_ML_RESTORE0))
    else $error("Margin-low restore value wrong");
  AST_MH_RESTORE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    restore_i |=> margin_high_step_o == ($past(option_bits[`MLO_OPT_RSMHI_BIT]) ?
    `MLO_MH_RESTORE1 : `MLO_MH_RESTORE0))
    else $error("Margin-high restore value wrong");
  AST_REF_BOUND: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $stable(target) && $stable(rate) && rate != 8'h00 |=> ##[0:300] amp_reference_o == target
    || !$stable(target))
    else $error("Reference failed to reach bounded target");
  AST_PG_OV: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    pg_state == mlo_pkg::MLO_PG_GOOD && fb_pct_i > ov_warn
    |=> pg_state == mlo_pkg::MLO_PG_OVER)
    else $error("Over-voltage warn missed");
  AST_PG_HYST: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    pg_state == mlo_pkg::MLO_PG_OVER && fb_pct_i >= `MLO_PG_HYST_HI
    |=> !reset_or_good_pin_o)
    else $error("Power-good recovered too early");
  AST_NEGLIM: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    option_bits[`MLO_OPT_NEGLIM_BIT] |=> !neg_limit_enable_o)
    else $error("Negative limit still enabled");
  AST_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !option_bits[`MLO_OPT_RUN_BIT] |=> $stable(read_vout_o))
    else $error("Reading updated while stopped");
  AST_VONLY: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    option_bits[`MLO_OPT_VONLY_BIT] |=> $stable(read_iout_o) && $stable(read_temp_o))
    else $error("Current or temperature updated in voltage-only mode");
  COV_SLAVE: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) refuse);
  COV_CLAMP: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $rose(invalid_data_o));
  COV_PG: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    pg_state == mlo_pkg::MLO_PG_OVER ##1 pg_state == mlo_pkg::MLO_PG_GOOD);
endmodule : mlo_regs

/* tb/mlo_host.sv */
// Command host model driving the register group access port
`timescale 1ns/100ps
module mlo_host (
  input  wire logic        sys_clk_i,
  input  wire logic        cmd_ack_i,
  input  wire logic        cmd_nack_i,
  input  wire logic [15:0] cmd_rdata_i,
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic [7:0]       cmd_code_o,
  output logic [15:0]      cmd_wdata_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_wdata_o = 16'h5A5A;
  end
  // One-cycle request; answer stands in the following cycle
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ack, output logic nack);
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_code_o  = code;
    cmd_wdata_o = wd;
    @(negedge sys_clk_i);
    rd   = cmd_rdata_i;
    ack  = cmd_ack_i;
    nack = cmd_nack_i;
    cmd_valid_o = 1'b0;
    cmd_wdata_o = ~wd;
  endtask : xfer
endmodule : mlo_host

/* tb/tb.sv */
// Self-checking bench for the margin, threshold and options register group
`timescale 1ns/100ps
module tb;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, loop_slave_i = 1'b0, restore_i = 1'b0;
  logic store_all_i = 1'b0, margin_low_sel_i = 1'b0, sample_i = 1'b0;
  logic cmd_valid_i, cmd_write_i, cmd_ack_o, cmd_nack_o, invalid_command_fault_o;
  logic invalid_data_o, alert_o, nv_store_o, reset_or_good_pin_o, neg_limit_enable_o;
  logic meas_iout_temp_o, akv, nkv;
  logic [7:0]  cmd_code_i, fb_pct_i = 8'h64, rate_rise_i = 8'hFF, rate_trans_i = 8'hFF;
  logic [11:0] base_ref_i = 12'h3E8, ref_max_i = 12'hFFF, amp_reference_o;
  logic [11:0] ref_min_i = 12'h000;
  logic [7:0]  rate_fall_i = 8'h00;
  logic [15:0] cmd_wdata_i, cmd_rdata_o, nv_options_o, read_vout_o, read_iout_o;
  logic [15:0] read_temp_o, margin_high_step_o, rdv, vout_sample_i = 16'h0000;
  logic [15:0] iout_sample_i = 16'h0000, temp_sample_i = 16'h0000;
  mlo_pkg::mlo_ramp_state_t ramp_state_i = mlo_pkg::MLO_RAMP_STEADY;
  int n_mismatch = 0, cmp_count = 0;
  localparam logic [15:0] ML_IN [5]  = '{16'hFFC0, 16'hFFFF, 16'hFFE5, 16'hFF80, 16'h0005};
  localparam logic [15:0] ML_EXP [5] = '{16'hFFC0, 16'hFFFF, 16'hFFE5, 16'hFFC0, 16'hFFFF};
  localparam logic [7:0] OV_WARN [4] = '{8'd112, 8'd110, 8'd112, 8'd112};
  localparam logic [7:0] UV_WARN [4] = '{8'd88, 8'd90, 8'd78, 8'd64};

  always #25 sys_clk_i = ~sys_clk_i;

  mlo_regs #(.REF_W(12)) u_mlo_regs (
    .sys_clk_i, .resetn_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_wdata_i,
    .loop_slave_i, .restore_i, .store_all_i, .margin_low_sel_i, .margin_high_sel_i(1'b0),
    .base_ref_i, .ref_max_i, .ref_min_i, .trim_i(16'h0000), .ramp_state_i,
    .rate_rise_i, .rate_trans_i, .rate_fall_i, .fb_pct_i, .sample_i,
    .vout_sample_i, .iout_sample_i, .temp_sample_i, .cmd_rdata_o, .cmd_ack_o, .cmd_nack_o,
    .invalid_command_fault_o, .invalid_data_o, .alert_o, .nv_options_o, .nv_store_o,
    .amp_reference_o, .reset_or_good_pin_o, .neg_limit_enable_o, .meas_iout_temp_o,
    .read_vout_o, .read_iout_o, .read_temp_o, .margin_high_step_o);

  mlo_host u_mlo_host (
    .sys_clk_i, .cmd_ack_i(cmd_ack_o), .cmd_nack_i(cmd_nack_o), .cmd_rdata_i(cmd_rdata_o),
    .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i),
    .cmd_wdata_o(cmd_wdata_i));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] code, input logic [15:0] d);
    u_mlo_host.xfer(1'b1, code, d, rdv, akv, nkv);
  endtask : wr

  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input string name);
    u_mlo_host.xfer(1'b0, code, 16'h0000, rdv, akv, nkv);
    check(name, rdv, exp);
    check("read_ack", {14'h0, akv, nkv}, 16'h0002);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : wait_cyc

  task automatic fb_chk(input logic [7:0] fb, input logic exp);
    fb_pct_i = fb;
    wait_cyc(4);
    check("power_good", {15'h0, reset_or_good_pin_o}, {15'h0, exp});
  endtask : fb_chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #(50 * 4000);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    wait_cyc(16);
    resetn_i = 1'b1;
    check("neg_limit_en", {15'h0, neg_limit_enable_o}, 16'h0001);
    check("meas_it", {15'h0, meas_iout_temp_o}, 16'h0001);
    check("mh_step", margin_high_step_o, 16'h0009);
    rd_chk(8'hD6, 16'hFFF7, "ml_reset");
    rd_chk(8'hD7, 16'h0000, "pct_reset");
    rd_chk(8'hE5, 16'h1184, "opt_reset");
    check("alert_idle", {15'h0, alert_o}, 16'h0000);
    // Loop slave refuses both commands and ignores the write
    loop_slave_i = 1'b1;
    wr(8'hD6, 16'hFFC5);
    check("slave_nack", {15'h0, nkv}, 16'h0001);
    u_mlo_host.xfer(1'b0, 8'hD7, 16'h0000, rdv, akv, nkv);
    check("slave_nack_rd", {14'h0, akv, nkv}, 16'h0001);
    check("cmd_fault", {15'h0, invalid_command_fault_o}, 16'h0001);
    check("alert_slave", {15'h0, alert_o}, 16'h0001);
    loop_slave_i = 1'b0;
    rd_chk(8'hD6, 16'hFFF7, "ml_ignored");
    for (int i = 0; i < 5; i++) begin
      wr(8'hD6, ML_IN[i]);
      rd_chk(8'hD6, ML_EXP[i], "ml_value");
      if (i == 2) check("ivd_clear", {15'h0, invalid_data_o}, 16'h0000);
    end
    check("ivd_set", {15'h0, invalid_data_o}, 16'h0001);
    wr(8'hD7, 16'hFFFF);
    rd_chk(8'hD7, 16'h0003, "pct_mask");
    for (int s = 0; s < 4; s++) begin
      wr(8'hD7, 16'(s));
      fb_chk(8'd100, 1'b1);
      fb_chk(OV_WARN[s], 1'b1);
      fb_chk(OV_WARN[s] + 8'd1, 1'b0);
      fb_chk(8'd105, 1'b0);
      fb_chk(8'd104, 1'b1);
      fb_chk(UV_WARN[s], 1'b1);
      fb_chk(UV_WARN[s] - 8'd1, 1'b0);
      fb_chk(8'd95, 1'b0);
      fb_chk(8'd96, 1'b1);
    end
    wr(8'hE5, 16'hFFFF);
    rd_chk(8'hE5, 16'h7FFF, "options");
    check("neg_limit_off", {15'h0, neg_limit_enable_o}, 16'h0000);
    check("meas_vonly", {15'h0, meas_iout_temp_o}, 16'h0000);
    store_all_i = 1'b1;
    wait_cyc(1);
    check("nv_store", {15'h0, nv_store_o}, 16'h0001);
    store_all_i = 1'b0;
    wait_cyc(2);
    check("nv_image", nv_options_o, 16'h7FE7);
    restore_i = 1'b1;
    wait_cyc(1);
    restore_i = 1'b0;
    rd_chk(8'hD6, 16'hFFF1, "ml_restore1");
    check("mh_restore1", margin_high_step_o, 16'h000F);
    wr(8'hE5, 16'h0004);
    restore_i = 1'b1;
    wait_cyc(1);
    restore_i = 1'b0;
    rd_chk(8'hD6, 16'hFFF7, "ml_restore0");
    check("mh_restore0", margin_high_step_o, 16'h0009);
    // Telemetry: run, voltage-only, then stopped
    for (int m = 0; m < 3; m++) begin
      wr(8'hE5, (m == 0) ? 16'h0004 : (m == 1) ? 16'h000C : 16'h0000);
      vout_sample_i = 16'h1111 * 16'(m + 1);
      iout_sample_i = 16'h2222 * 16'(m + 1);
      temp_sample_i = 16'h3333 * 16'(m + 1);
      sample_i = 1'b1;
      wait_cyc(1);
      sample_i = 1'b0;
      wait_cyc(3);
      check("vout", read_vout_o, (m == 2) ? 16'h2222 : vout_sample_i);
      check("iout", read_iout_o, 16'h2222);
      check("temp", read_temp_o, 16'h3333);
    end
    check("ref_base", {4'h0, amp_reference_o}, 16'h03E8);
    margin_low_sel_i = 1'b1;
    wait_cyc(10);
    check("ref_margin", {4'h0, amp_reference_o}, 16'h03DF);
    ref_max_i = 12'h3D0;
    wait_cyc(10);
    check("ref_max", {4'h0, amp_reference_o}, 16'h03D0);
    ref_max_i = 12'hFFF;
    rate_trans_i = 8'h00;
    margin_low_sel_i = 1'b0;
    wait_cyc(10);
    check("ref_frozen", {4'h0, amp_reference_o}, 16'h03D0);
    ramp_state_i = mlo_pkg::MLO_RAMP_SOFT_START;
    wait_cyc(10);
    check("ref_rise", {4'h0, amp_reference_o}, 16'h03E8);
    ramp_state_i = mlo_pkg::MLO_RAMP_SOFT_STOP;
    rate_trans_i = 8'hFF;
    margin_low_sel_i = 1'b1;
    wait_cyc(10);
    check("ref_fall", {4'h0, amp_reference_o}, 16'h03E8);
    rate_fall_i = 8'h01;
    wait_cyc(10);
    check("ref_fall_run", {4'h0, amp_reference_o}, 16'h03DF);
    ramp_state_i = mlo_pkg::MLO_RAMP_OFF_DELAY;
    rate_fall_i = 8'h00;
    ref_min_i = 12'h3F0;
    wait_cyc(3);
    check("ref_min", {4'h0, amp_reference_o}, 16'h03F0);
    give_verdict();
  end
endmodule : tb
